// *** core/sts_pkg.sv ***
// shared constants and types for the sweep trigger sequencer
package sts_pkg;
	localparam int MAX_POINTS = 401;
	localparam logic [8:0] LAST_POINT_MAX = 9'h190;
	localparam int PT_W = 9;
	localparam int RD_W = 16;
	localparam int AVG_READS = 4;
	localparam logic [1:0] AVG_LAST = 2'h3;
	localparam int AVG_SHIFT = 2;
	localparam int FREQ_W = 29;
	localparam int RBW_STEPS = 11;
	localparam logic [3:0] RBW_TOP = 4'hA;
	localparam logic [3:0] RBW_ANALOG_MIN = 4'h3;
	localparam logic [3:0] RBW_RESET = 4'hA;
	// lower frequency edge (Hz) of each auto bandwidth above 3 Hz
	localparam logic [28:0] RBW_EDGE [10] = '{
		29'h00003E8, 29'h0000BB8, 29'h0002710, 29'h0007530,
		29'h00186A0, 29'h00493E0, 29'h00F4240, 29'h02DC6C0,
		29'h0989680, 29'h1C9C380};
	localparam logic [2:0] ATT_MAX_STEP = 3'h5;
	localparam logic [2:0] ATT_RESET = 3'h0;
	localparam logic signed [6:0] DBM_STEP = 7'sh0A;
	localparam logic signed [6:0] DBM_CAP = 7'sh14;
	localparam logic signed [6:0] SPEC_NORMAL = -7'sh14;
	localparam logic signed [6:0] SPEC_LOWDIST = -7'sh1E;
	localparam logic signed [6:0] SPEC_HISENS = -7'sh28;
	localparam logic signed [6:0] OTHER_NORMAL = -7'sh0A;
	localparam logic signed [6:0] OTHER_HISENS = -7'sh14;
	typedef enum logic [1:0] {SWEEP_CONT, SWEEP_SINGLE, SWEEP_MANUAL}
		sts_sweep_t;
	typedef enum logic [1:0] {IFR_NORMAL, IFR_SECOND, IFR_THIRD} sts_ifr_t;
endpackage : sts_pkg

// *** core/sts_avg_if.sv ***
// readings toward the point averager and its result back
`timescale 1ns/10ps
interface sts_avg_if;
	logic clear;
	logic avg_on;
	logic rd_valid;
	logic [15:0] rd_value;
	logic res_valid;
	logic [15:0] res_value;
	modport seq (output clear, avg_on, rd_valid, rd_value,
		input res_valid, res_value);
	modport avg (input clear, avg_on, rd_valid, rd_value,
		output res_valid, res_value);
endinterface : sts_avg_if

// *** core/sts_point_avg.sv ***
// averages four readings per point when the video filter is on
`timescale 1ns/10ps
module sts_point_avg (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// readings and result
	sts_avg_if.avg av
);
	logic [1:0] count;
	logic [17:0] sum;
	logic [17:0] next_sum;

	assign next_sum = sum + {2'h0, av.rd_value};

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count <= 2'h0;
			sum <= 18'h00000;
			av.res_valid <= 1'b0;
			av.res_value <= 16'h0000;
		end else begin
			av.res_valid <= 1'b0;
			if (av.clear) begin
				count <= 2'h0;
				sum <= 18'h00000;
			end else if (av.rd_valid && !av.avg_on) begin
				av.res_valid <= 1'b1;
				av.res_value <= av.rd_value;
			end else if (av.rd_valid) begin
				count <= count + 2'h1;
				sum <= next_sum;
				if (count == sts_pkg::AVG_LAST) begin
					av.res_valid <= 1'b1;
					av.res_value <= next_sum[sts_pkg::AVG_SHIFT +: 16];
					sum <= 18'h00000;
				end
			end
		end
	end

	a_avg_fourth: assert property (@(posedge clock) disable iff (sys_rst)
		av.rd_valid && av.avg_on && !av.clear && count == 2'h3
		|=> av.res_valid) else $error("mean not given on fourth reading");
	a_avg_early: assert property (@(posedge clock) disable iff (sys_rst)
		av.rd_valid && av.avg_on && count != 2'h3 |=> !av.res_valid)
		else $error("averaged result before four readings");
endmodule : sts_point_avg

// *** core/sts_sequencer.sv ***
// sweep and point trigger sequencer with receiver setting decode
`timescale 1ns/10ps
module sts_sequencer (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// sweep mode and restart
	input wire logic continuous_sweep_cmd,
	input wire logic single_sweep_cmd,
	input wire logic manual_sweep_cmd,
	input wire logic sweep_restart_cmd,
	input wire logic sweep_restart_key,
	input wire logic [8:0] num_points,
	// point pacing and triggers
	input wire logic internal_point_pacing_cmd,
	input wire logic external_point_pacing_cmd,
	input wire logic point_fire_cmd,
	input wire logic point_fire_softkey,
	input wire logic ext_pulse_input,
	// manual marker
	input wire logic manual_point_wr,
	input wire logic [8:0] manual_point_data,
	input wire logic knob_up,
	input wire logic knob_down,
	// measurement engine
	input wire logic meas_done,
	input wire logic [15:0] meas_value,
	output logic meas_start,
	output logic [8:0] point_index,
	output logic point_result_valid,
	output logic [15:0] point_result,
	output logic sweep_done,
	output logic sweep_busy,
	output logic [8:0] marker_point,
	// video filter
	input wire logic video_avg_on_cmd,
	input wire logic video_avg_off_cmd,
	input wire logic video_key,
	output logic video_indicator,
	// resolution bandwidth
	input wire logic bw_auto,
	input wire logic [3:0] bw_manual_sel,
	input wire logic sweep_is_freq,
	input wire logic sweep_is_log,
	input wire logic span_zero,
	input wire logic [28:0] meas_freq_hz,
	input wire logic [28:0] span_hz,
	output logic [3:0] rbw_code,
	output logic rbw_digital,
	// IF range and attenuators
	input wire logic spectrum_cfg,
	input wire logic if_range_normal_cmd,
	input wire logic if_range_second_cmd,
	input wire logic if_range_third_cmd,
	input wire logic ref1_atten_cmd,
	input wire logic test1_atten_cmd,
	input wire logic ref2_atten_cmd,
	input wire logic test2_atten_cmd,
	input wire logic [2:0] atten_step,
	output logic [1:0] if_range,
	output logic signed [6:0] ref_input_a_range_dbm,
	output logic signed [6:0] test_input_a_range_dbm,
	output logic signed [6:0] ref_input_b_range_dbm,
	output logic signed [6:0] test_input_b_range_dbm
);
	typedef enum logic [2:0] {ST_IDLE, ST_POINT, ST_ISSUE, ST_MEAS,
		ST_CHECK, ST_WAIT} sts_state_t;

	sts_state_t state;
	sts_pkg::sts_sweep_t sweep_mode;
	sts_pkg::sts_ifr_t ifr;
	logic ext_pace;
	logic pulse_s1, pulse_s2, pulse_s3;
	logic ext_rise, point_fire_cmd_event, restart_req, is_last;
	logic [8:0] last_idx;
	logic [3:0] next_rbw;
	logic [2:0] atten [4];
	logic signed [6:0] range_dbm [4];
	logic [3:0] atten_cmd;

	sts_avg_if avg_bus ();
	sts_point_avg u_avg (
		.clock(clock),
		.sys_rst(sys_rst),
		.av(avg_bus.avg)
	);

	// two-stage synchroniser, edge taken from the second and third stages
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_s1 <= 1'b0;
			pulse_s2 <= 1'b0;
			pulse_s3 <= 1'b0;
		end else begin
			pulse_s1 <= ext_pulse_input;
			pulse_s2 <= pulse_s1;
			pulse_s3 <= pulse_s2;
		end
	end
	assign ext_rise = pulse_s2 && !pulse_s3;
	assign point_fire_cmd_event = ext_rise || point_fire_cmd || point_fire_softkey;
	assign restart_req = sweep_restart_cmd || sweep_restart_key;

	// point count of 0 is taken as one point, above the limit as the limit
	always_comb begin
		if (num_points == 9'h000)
			last_idx = 9'h000;
		else if (num_points - 9'h001 > sts_pkg::LAST_POINT_MAX)
			last_idx = sts_pkg::LAST_POINT_MAX;
		else
			last_idx = num_points - 9'h001;
	end
	assign is_last = point_index >= last_idx;

	// mode and pacing selection
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sweep_mode <= sts_pkg::SWEEP_CONT;
			ext_pace <= 1'b0;
		end else begin
			if (continuous_sweep_cmd)
				sweep_mode <= sts_pkg::SWEEP_CONT;
			else if (single_sweep_cmd)
				sweep_mode <= sts_pkg::SWEEP_SINGLE;
			else if (manual_sweep_cmd)
				sweep_mode <= sts_pkg::SWEEP_MANUAL;
			if (internal_point_pacing_cmd)
				ext_pace <= 1'b0;
			else if (external_point_pacing_cmd)
				ext_pace <= 1'b1;
		end
	end

	// manual marker, kept inside the current sweep length
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			marker_point <= 9'h000;
		end else if (manual_point_wr) begin
			marker_point <= (manual_point_data > last_idx) ? last_idx :
				manual_point_data;
		end else if (knob_up && marker_point < last_idx) begin
			marker_point <= marker_point + 9'h001;
		end else if (knob_down && marker_point != 9'h000) begin
			marker_point <= marker_point - 9'h001;
		end else if (marker_point > last_idx) begin
			marker_point <= last_idx;
		end
	end

	// sweep and point sequencing
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			point_index <= 9'h000;
			meas_start <= 1'b0;
			sweep_done <= 1'b0;
			point_result_valid <= 1'b0;
			point_result <= 16'h0000;
		end else begin
			meas_start <= 1'b0;
			sweep_done <= 1'b0;
			point_result_valid <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (sweep_mode == sts_pkg::SWEEP_MANUAL) begin
						point_index <= marker_point;
						state <= ST_POINT;
					end else if (sweep_mode == sts_pkg::SWEEP_CONT
						|| restart_req) begin
						point_index <= 9'h000;
						state <= ST_POINT;
					end
				end
				ST_POINT: state <= ST_ISSUE;
				ST_ISSUE: begin
					meas_start <= 1'b1;
					state <= ST_MEAS;
				end
				// triggers are simply not looked at here, so none queue up
				ST_MEAS: if (meas_done) state <= ST_CHECK;
				ST_CHECK: begin
					if (!avg_bus.res_valid) begin
						state <= ST_ISSUE;
					end else begin
						point_result_valid <= 1'b1;
						point_result <= avg_bus.res_value;
						state <= ext_pace ? ST_WAIT : ST_POINT;
						if (sweep_mode == sts_pkg::SWEEP_MANUAL) begin
							point_index <= marker_point;
						end else if (is_last) begin
							sweep_done <= 1'b1;
							point_index <= 9'h000;
							if (sweep_mode == sts_pkg::SWEEP_SINGLE)
								state <= ST_IDLE;
						end else begin
							point_index <= point_index + 9'h001;
						end
					end
				end
				ST_WAIT: begin
					if (point_fire_cmd_event || !ext_pace) begin
						state <= ST_POINT;
						if (sweep_mode == sts_pkg::SWEEP_MANUAL)
							point_index <= marker_point;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			sweep_busy <= 1'b0;
		else
			sweep_busy <= state != ST_IDLE;
	end

	// averager is cleared and armed at the start of each point
	assign avg_bus.clear = state == ST_POINT;
	assign avg_bus.rd_valid = state == ST_MEAS && meas_done;
	assign avg_bus.rd_value = meas_value;
	assign avg_bus.avg_on = video_indicator;

	// video filter; the key wins over a command in the same cycle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			video_indicator <= 1'b0;
		else if (video_key)
			video_indicator <= !video_indicator;
		else if (video_avg_on_cmd)
			video_indicator <= 1'b1;
		else if (video_avg_off_cmd)
			video_indicator <= 1'b0;
	end

	// frequency to bandwidth code, 0 is 3 Hz and 10 is 300 kHz
	function automatic logic [3:0] rbw_lookup(input logic [28:0] f);
		logic [3:0] code;
		code = 4'h0;
		for (int i = 0; i < sts_pkg::RBW_STEPS - 1; i++) begin
			if (f >= sts_pkg::RBW_EDGE[i])
				code = 4'(i + 1);
		end
		return code;
	endfunction : rbw_lookup

	// linear span choice is made on the first point only and then held
	always_comb begin
		next_rbw = rbw_code;
		if (state == ST_POINT) begin
			if (!bw_auto)
				next_rbw = (bw_manual_sel > sts_pkg::RBW_TOP) ?
					sts_pkg::RBW_TOP : bw_manual_sel;
			else if (sweep_is_freq && !sweep_is_log && !span_zero) begin
				if (point_index == 9'h000)
					next_rbw = rbw_lookup(span_hz);
			end else
				next_rbw = rbw_lookup(meas_freq_hz);
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rbw_code <= sts_pkg::RBW_RESET;
			rbw_digital <= 1'b0;
		end else begin
			rbw_code <= next_rbw;
			rbw_digital <= next_rbw < sts_pkg::RBW_ANALOG_MIN;
		end
	end

	// one IF range for all inputs; the third exists only for spectrum
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			ifr <= sts_pkg::IFR_NORMAL;
		else if (if_range_normal_cmd)
			ifr <= sts_pkg::IFR_NORMAL;
		else if (if_range_second_cmd)
			ifr <= sts_pkg::IFR_SECOND;
		else if (if_range_third_cmd && spectrum_cfg)
			ifr <= sts_pkg::IFR_THIRD;
		else if (!spectrum_cfg && ifr == sts_pkg::IFR_THIRD)
			ifr <= sts_pkg::IFR_SECOND;
	end
	assign if_range = ifr;

	assign atten_cmd = {test2_atten_cmd, ref2_atten_cmd, test1_atten_cmd,
		ref1_atten_cmd};

	function automatic logic signed [6:0] range_of(input logic [2:0] att,
		input sts_pkg::sts_ifr_t r, input logic spec);
		logic signed [6:0] base;
		logic signed [6:0] sum;
		if (spec)
			base = (r == sts_pkg::IFR_NORMAL) ? sts_pkg::SPEC_NORMAL :
				(r == sts_pkg::IFR_SECOND) ? sts_pkg::SPEC_LOWDIST :
				sts_pkg::SPEC_HISENS;
		else
			base = (r == sts_pkg::IFR_NORMAL) ? sts_pkg::OTHER_NORMAL :
				sts_pkg::OTHER_HISENS;
		sum = 7'(base + 7'(sts_pkg::DBM_STEP * $signed({1'b0, att})));
		return (sum > sts_pkg::DBM_CAP) ? sts_pkg::DBM_CAP : sum;
	endfunction : range_of

	for (genvar g = 0; g < 4; g++) begin : g_input
		always_ff @(posedge clock or posedge sys_rst) begin
			if (sys_rst) begin
				atten[g] <= sts_pkg::ATT_RESET;
				range_dbm[g] <= 7'sh00;
			end else begin
				if (atten_cmd[g])
					atten[g] <= (atten_step > sts_pkg::ATT_MAX_STEP) ?
						sts_pkg::ATT_MAX_STEP : atten_step;
				range_dbm[g] <= range_of(atten[g], ifr, spectrum_cfg);
			end
		end
	end

	assign ref_input_a_range_dbm = range_dbm[0];
	assign test_input_a_range_dbm = range_dbm[1];
	assign ref_input_b_range_dbm = range_dbm[2];
	assign test_input_b_range_dbm = range_dbm[3];

	sequence s_point_end;
		state == ST_CHECK && avg_bus.res_valid;
	endsequence
	sequence s_wait_fire;
		state == ST_WAIT && ext_pace && ext_rise;
	endsequence

	a_auto_start: assert property (@(posedge clock) disable iff (sys_rst)
		state == ST_IDLE && sweep_mode == sts_pkg::SWEEP_CONT
		|=> state == ST_POINT) else $error("continuous sweep did not start");
	a_cont_wrap: assert property (@(posedge clock) disable iff (sys_rst)
		s_point_end and sweep_mode == sts_pkg::SWEEP_CONT && is_last
		&& !ext_pace |=> state == ST_POINT && point_index == 9'h000
		&& sweep_done) else $error("continuous sweep did not wrap");
	a_single_halt: assert property (@(posedge clock) disable iff (sys_rst)
		s_point_end and sweep_mode == sts_pkg::SWEEP_SINGLE && is_last
		|=> state == ST_IDLE ##1 (state == ST_IDLE || $past(restart_req)))
		else $error("single sweep did not halt");
	a_point_limit: assert property (@(posedge clock) disable iff (sys_rst)
		point_index <= sts_pkg::LAST_POINT_MAX)
		else $error("point index past limit");
	a_int_nowait: assert property (@(posedge clock) disable iff (sys_rst)
		s_point_end and !ext_pace && sweep_mode != sts_pkg::SWEEP_SINGLE
		|=> state == ST_POINT ##2 meas_start)
		else $error("internal pacing waited");
	a_ext_fire: assert property (@(posedge clock) disable iff (sys_rst)
		s_wait_fire |=> state == ST_POINT ##2 meas_start)
		else $error("external edge did not fire a point");
	a_point_fire_cmd_drop: assert property (@(posedge clock) disable iff (sys_rst)
		state == ST_WAIT && ext_pace && !point_fire_cmd_event |=> state == ST_WAIT)
		else $error("point fired without a trigger");
	a_rbw_path: assert property (@(posedge clock) disable iff (sys_rst)
		rbw_digital == (rbw_code < sts_pkg::RBW_ANALOG_MIN))
		else $error("bandwidth path does not match code");
	a_range_cap: assert property (@(posedge clock) disable iff (sys_rst)
		range_dbm[0] <= sts_pkg::DBM_CAP && range_dbm[3] <= sts_pkg::DBM_CAP)
		else $error("input range above cap");
endmodule : sts_sequencer

// *** test/sts_engine_model.sv ***
// behavioural measurement engine answering each reading request
`timescale 1ns/10ps
module sts_engine_model (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// request and answer
	input wire logic meas_start,
	input wire logic [3:0] delay,
	output logic meas_done,
	output logic [15:0] meas_value
);
	logic [4:0] cnt;
	logic [15:0] seq;

	// a reading finishes delay+1 cycles after its request
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 5'h00;
			meas_done <= 1'b0;
			meas_value <= 16'h0000;
			seq <= 16'h1234;
		end else begin
			meas_done <= 1'b0;
			// value is only valid with done; it toggles otherwise
			meas_value <= ~meas_value;
			if (meas_start) begin
				cnt <= {1'b0, delay} + 5'h01;
			end else if (cnt == 5'h01) begin
				cnt <= 5'h00;
				meas_done <= 1'b1;
				meas_value <= seq;
				seq <= seq * 16'h0005 + 16'h003B;
			end else if (cnt != 5'h00) begin
				cnt <= cnt - 5'h01;
			end
		end
	end
endmodule : sts_engine_model

// *** test/tb.sv ***
// self-checking bench for the sweep trigger sequencer
`timescale 1ns/10ps
module tb;
	logic clock, sys_rst, ext_pulse, bw_auto, s_freq, s_log, spec;
	logic mstart, mdone, prv, sdone, vind, rdig, busy, szero;
	logic [21:0] cmd;
	logic [8:0] npts, mdata, pidx, mark;
	logic [3:0] bw_sel, dly, rbw;
	logic [28:0] freq, span;
	logic [2:0] astep;
	logic [15:0] mval, pres;
	logic [1:0] ifr;
	logic signed [6:0] rng [4];
	logic [15:0] q[$];
	logic [17:0] acc;
	int nr, fails, num_checks, starts, results, s0, r0, k, j, r, cfg, st, base;
	bit vid_exp;
	int edge_hz [10] = '{1000, 3000, 10000, 30000, 100000, 300000, 1000000,
		3000000, 10000000, 30000000};

	sts_sequencer u_sts_sequencer (.clock(clock), .sys_rst(sys_rst),
		.continuous_sweep_cmd(cmd[0]), .single_sweep_cmd(cmd[1]),
		.manual_sweep_cmd(cmd[2]), .sweep_restart_cmd(cmd[3]),
		.sweep_restart_key(cmd[4]), .num_points(npts),
		.internal_point_pacing_cmd(cmd[5]),
		.external_point_pacing_cmd(cmd[6]), .point_fire_cmd(cmd[7]),
		.point_fire_softkey(cmd[8]), .ext_pulse_input(ext_pulse),
		.manual_point_wr(cmd[9]), .manual_point_data(mdata),
		.knob_up(cmd[10]), .knob_down(cmd[11]), .meas_done(mdone),
		.meas_value(mval), .meas_start(mstart), .point_index(pidx),
		.point_result_valid(prv), .point_result(pres), .sweep_done(sdone),
		.sweep_busy(busy), .marker_point(mark), .video_avg_on_cmd(cmd[12]),
		.video_avg_off_cmd(cmd[13]), .video_key(cmd[14]),
		.video_indicator(vind), .bw_auto(bw_auto), .bw_manual_sel(bw_sel),
		.sweep_is_freq(s_freq), .sweep_is_log(s_log), .span_zero(szero),
		.meas_freq_hz(freq), .span_hz(span), .rbw_code(rbw),
		.rbw_digital(rdig), .spectrum_cfg(spec),
		.if_range_normal_cmd(cmd[15]), .if_range_second_cmd(cmd[16]),
		.if_range_third_cmd(cmd[17]), .ref1_atten_cmd(cmd[18]),
		.test1_atten_cmd(cmd[19]), .ref2_atten_cmd(cmd[20]),
		.test2_atten_cmd(cmd[21]), .atten_step(astep), .if_range(ifr),
		.ref_input_a_range_dbm(rng[0]), .test_input_a_range_dbm(rng[1]),
		.ref_input_b_range_dbm(rng[2]), .test_input_b_range_dbm(rng[3]));

	sts_engine_model u_sts_engine_model (.clock(clock), .sys_rst(sys_rst),
		.meas_start(mstart), .delay(dly), .meas_done(mdone),
		.meas_value(mval));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task summarize;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize

	task chk(input logic [15:0] g, input logic [15:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk

	task rest(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : rest

	// sel 0 sweep end, 1 reading request, 2 point result
	task wait_ev(input int sel, input int lim);
		int n;
		bit hit;
		n = 0;
		hit = 0;
		while (!hit && n < lim) begin
			rest(1);
			n++;
			hit = sel == 0 ? sdone === 1'b1 : sel == 1 ? mstart === 1'b1 :
				prv === 1'b1;
		end
		if (!hit) begin
			chk(16'h0, 16'h1, "wait ran out");
			summarize();
		end
	endtask : wait_ev

	task pulse(input int i);
		@(posedge clock);
		cmd <= 22'h1 << i;
		@(posedge clock);
		cmd <= '0;
	endtask : pulse

	task rbw_chk(input logic [28:0] f, input logic [3:0] e);
		freq <= f;
		repeat (2) wait_ev(2, 200);
		chk(16'(rbw), 16'(e), "bandwidth code");
	endtask : rbw_chk

	// expectations are noted from engine readings, checked on results
	always @(posedge clock) begin
		if (mstart === 1'b1) starts++;
		if (prv === 1'b1) begin
			results++;
			if (q.size() == 0) chk(16'h1, 16'h0, "result unasked");
			else chk(pres, q.pop_front(), "point result");
		end
		if (mdone === 1'b1) begin
			acc = acc + 18'(mval);
			nr++;
			if (nr == (vid_exp ? 4 : 1)) begin
				q.push_back(vid_exp ? acc[17:2] : acc[15:0]);
				acc = '0;
				nr = 0;
			end
		end
	end

	initial begin
		sys_rst = 1'b1; cmd = '0; ext_pulse = 1'b0; bw_auto = 1'b0;
		s_freq = 1'b0; s_log = 1'b0; spec = 1'b0; npts = 9'h004;
		szero = 1'b0;
		mdata = 9'h002; bw_sel = 4'h0; dly = 4'h3; freq = '0; span = '0;
		astep = 3'h0; acc = '0; nr = 0; fails = 0; num_checks = 0;
		starts = 0; results = 0; vid_exp = 1'b0;
		void'($urandom(37088));
		rest(1);
		chk(16'({rbw, ifr, vind}), 16'h0050, "reset values");
		@(posedge clock);
		sys_rst <= 1'b0;
		wait_ev(1, 10);
		chk(16'(busy), 16'h1, "busy in sweep");
		repeat (2) wait_ev(0, 400);
		$display("test continuous done");
		pulse(1);
		wait_ev(0, 400);
		s0 = starts;
		rest(30);
		chk(16'(starts - s0), 16'h0, "single halt");
		chk(16'(busy), 16'h0, "idle after halt");
		r0 = results;
		pulse(4);
		wait_ev(0, 400);
		rest(3);
		chk(16'(results - r0), 16'h4, "points per sweep");
		npts <= 9'h1FF;
		r0 = results;
		pulse(3);
		wait_ev(0, 8000);
		rest(3);
		chk(16'(results - r0), 16'h191, "point cap");
		$display("test single done");
		pulse(12);
		vid_exp = 1'b1;
		rest(2);
		chk(16'(vind), 16'h1, "filter on");
		npts <= 9'h002;
		pulse(3);
		wait_ev(0, 400);
		rest(3);
		pulse(14);
		rest(2);
		chk(16'(vind), 16'h0, "key toggles off");
		pulse(14);
		rest(2);
		chk(16'(vind), 16'h1, "key toggles on");
		pulse(13);
		vid_exp = 1'b0;
		rest(2);
		chk(16'(vind), 16'h0, "filter off");
		$display("test video done");
		npts <= 9'h008;
		pulse(9);
		pulse(2);
		repeat (2) wait_ev(1, 100);
		chk(16'(pidx), 16'h2, "marker point");
		pulse(10);
		repeat (2) wait_ev(1, 100);
		chk(16'({pidx, mark}), 16'h0603, "knob moves marker");
		$display("test manual done");
		npts <= 9'h191;
		pulse(6);
		pulse(0);
		wait_ev(2, 200);
		rest(2);
		s0 = starts;
		rest(20);
		chk(16'(starts - s0), 16'h0, "waits for trigger");
		for (k = 7; k < 10; k++) begin
			s0 = starts;
			if (k < 9) pulse(k);
			else begin
				@(posedge clock);
				ext_pulse <= 1'b1;
				rest(6);
				ext_pulse <= 1'b0;
			end
			rest(40);
			chk(16'(starts - s0), 16'h1, "one point per trigger");
		end
		// slow engine so later triggers land in a measurement
		dly <= 4'hF;
		s0 = starts;
		pulse(7);
		rest(4);
		pulse(8);
		ext_pulse <= 1'b1;
		rest(4);
		ext_pulse <= 1'b0;
		rest(60);
		chk(16'(starts - s0), 16'h1, "busy triggers dropped");
		dly <= 4'h3;
		pulse(5);
		$display("test external done");
		for (k = 0; k < 11; k++) begin
			bw_sel <= 4'(k);
			repeat (2) wait_ev(2, 200);
			chk(16'(rbw), 16'(k), "manual bandwidth");
			chk(16'(rdig), 16'(k < 3), "filter path");
		end
		bw_auto <= 1'b1;
		for (k = 0; k < 11; k++) begin
			rbw_chk(k == 0 ? 29'h1 : 29'(edge_hz[k - 1]), 4'(k));
			rbw_chk(k == 10 ? 29'h1DCD6500 : 29'(edge_hz[k] - 1), 4'(k));
		end
		s_freq <= 1'b1;
		s_log <= 1'b1;
		rbw_chk(29'h0BB8, 4'h2);
		s_log <= 1'b0;
		span <= 29'h0C350;
		freq <= 29'h003E7;
		wait_ev(0, 8000);
		repeat (2) wait_ev(2, 200);
		chk(16'(rbw), 16'h4, "span bandwidth");
		szero <= 1'b1;
		repeat (2) wait_ev(2, 200);
		chk(16'(rbw), 16'h0, "zero span bandwidth");
		$display("test bandwidth done");
		for (cfg = 1; cfg >= 0; cfg--) begin
			for (r = 0; r <= cfg + 1; r++) begin
				spec <= cfg[0];
				pulse(15 + r);
				base = cfg ? -20 - 10 * r : -10 - 10 * r;
				for (j = 0; j < 4; j++) begin
					st = $urandom % 8;
					astep <= st[2:0];
					pulse(18 + j);
					st = st > 5 ? 5 : st;
					st = base + 10 * st > 20 ? 20 : base + 10 * st;
					rest(3);
					chk(16'(rng[j]), 16'(st), "input range");
				end
				chk(16'(ifr), 16'(r), "if range");
			end
		end
		pulse(17);
		rest(3);
		chk(16'(ifr), 16'h1, "third range refused");
		$display("test ranges done");
		summarize();
	end
endmodule : tb
